//--- core/duc_ctrl.sv
// dac update, reset and clear control with ahb-lite register port
`timescale 1ns/1ns
// Contract
// - rising edge of reset_n starts a sequence restoring input, gain, offset defaults
// - falling edge and low level of reset_n have no effect
// - after reset, outputs hold default-derived ground code until write plus load
// - clear low switches every output buffer to its group signal ground
// - load strobes arriving during clear are discarded
// - clear leaves input and output registers untouched; outputs return afterwards
// - each input, gain or offset write recalculates computed code; busy low meanwhile; a write mid-calculation restarts it for its own channels only
// - while busy low outside the reset sequence, writes accepted but no output transfer occurs
// - busy is wired-shared; device releases when done, any device holds it low
// - load falling during busy is remembered; outputs update when busy rises
// - load held low updates outputs every time busy returns high
// - source select write drives busy low for about 600 ns
// - one multiplier each for a and b computes addressed channels (1, 2, 8, 16) one after another
// - busy low time is (channels plus one) times 600 ns plus 300 ns
// - busy at most 1.5, 2.1, 5.7, 10.5 us for 1, 2, 8, 16 channels
// - load copies computed code a or b per channel source select bit
// - only channels whose computed code was recalculated since last load are refreshed
// - code equals input times (gain plus one) over 2^16 plus offset minus 2^15
module duc_ctrl #(
  parameter int unsigned RESET_CYC = duc_pkg::RESET_SEQ_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reset_n,
  input wire logic clear_to_ground_n,
  input wire logic load_outputs_n,
  input wire logic busy_n_in,
  output logic busy_n_out,
  output logic busy_n_oe_n,
  output logic [duc_pkg::NUM_CH-1:0] group_signal_ground
);
  import duc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] clr_s;
    logic [1:0] ld_s;
    logic [1:0] busy_s;
    logic rst_d;
    logic ld_d;
    logic bus_d;
    duc_state_t st;
    logic [18:0] cnt;
    logic [CH_W-1:0] ch;
    logic [CH_W:0] left;
    logic [1:0] scope;
    logic [NUM_CH-1:0] sel;
    logic [NUM_CH-1:0] dirty;
    logic pend;
    logic [31:0] cmd;
    logic dph;
    logic dwr;
    logic [11:0] daddr;
    logic [31:0] rdata;
    logic busy_n;
    logic [NUM_CH-1:0] gnd;
    logic [31:0] loads;
  } duc_st_t;

  duc_st_t s_r, s_nxt;
  logic [CODE_W-1:0] inp_a [NUM_CH];
  logic [CODE_W-1:0] inp_b [NUM_CH];
  logic [CODE_W-1:0] gain [NUM_CH];
  logic [CODE_W-1:0] offs [NUM_CH];
  logic [CODE_W-1:0] cc_a [NUM_CH];
  logic [CODE_W-1:0] cc_b [NUM_CH];
  logic [CODE_W-1:0] outr [NUM_CH];
  logic [CODE_W-1:0] res_a, res_b;
  logic wr_go, do_load, init_go, calc_slot;
  logic [CH_W-1:0] cur_ch;
  logic [2:0] cmd_tgt;

  assign cur_ch = s_r.ch;
  assign cmd_tgt = s_r.cmd[WR_TGT_LSB +: 3];

  duc_calc u_calc_a (
    .x(inp_a[cur_ch]),
    .m(gain[cur_ch]),
    .c(offs[cur_ch]),
    .y(res_a)
  );
  duc_calc u_calc_b (
    .x(inp_b[cur_ch]),
    .m(gain[cur_ch]),
    .c(offs[cur_ch]),
    .y(res_b)
  );

  always_comb begin
    s_nxt = s_r;
    wr_go = 1'b0;
    do_load = 1'b0;
    init_go = 1'b0;
    calc_slot = 1'b0;
    s_nxt.rst_s = {s_r.rst_s[0], reset_n};
    s_nxt.clr_s = {s_r.clr_s[0], clear_to_ground_n};
    s_nxt.ld_s = {s_r.ld_s[0], load_outputs_n};
    s_nxt.busy_s = {s_r.busy_s[0], busy_n_in};
    s_nxt.rst_d = s_r.rst_s[1];
    s_nxt.ld_d = s_r.ld_s[1];
    // bus: address phase captured, acted on in data phase
    s_nxt.dph = hsel && hready && htrans[1];
    s_nxt.dwr = hwrite;
    s_nxt.daddr = haddr[11:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      s_nxt.rdata = 32'h0;
      case (haddr[11:0])
        OFS_CTRL: s_nxt.rdata = {31'h0, s_r.pend};
        OFS_STATUS: s_nxt.rdata = {28'h0, s_r.st == ST_RESET, !s_r.busy_s[1], !s_r.busy_n,
                                   s_r.pend};
        OFS_SEL: s_nxt.rdata = {16'h0, s_r.sel};
        OFS_WRITE: s_nxt.rdata = s_r.loads;
        default: begin
          if (haddr[11:8] == OFS_OUT_BASE[11:8] && haddr[7:6] == 2'b00) begin
            s_nxt.rdata = {16'h0, outr[haddr[5:2]]};
          end
        end
      endcase
    end
    // falling load edge, or level low, arms a pending transfer
    if (s_r.ld_d && !s_r.ld_s[1]) begin
      s_nxt.pend = 1'b1;
    end
    if (!s_r.ld_s[1]) begin
      s_nxt.pend = 1'b1;
    end
    if (!s_r.clr_s[1]) begin
      s_nxt.pend = 1'b0;
    end
    s_nxt.gnd = {NUM_CH{!s_r.clr_s[1]}};
    case (s_r.st)
      ST_RESET: begin
        s_nxt.busy_n = 1'b0;
        init_go = (s_r.cnt == 19'd0);
        if (s_r.cnt == 19'(RESET_CYC - 1)) begin
          s_nxt.st = ST_IDLE;
          s_nxt.busy_n = 1'b1;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + 19'd1;
        end
      end
      ST_IDLE: begin
        // busy sampled high on the shared wire: no device is calculating
        if (s_r.pend && s_r.busy_s[1] && s_r.busy_n && s_r.clr_s[1]) begin
          do_load = 1'b1;
          s_nxt.pend = 1'b0;
          s_nxt.dirty = '0;
          s_nxt.loads = s_r.loads + 32'd1;
        end
      end
      ST_CALC: begin
        // one slot per channel, then one spare slot and a tail
        s_nxt.cnt = s_r.cnt + 19'd1;
        if (s_r.cnt == 19'(SLOT_CYC - 1)) begin
          s_nxt.cnt = '0;
          if (s_r.left != '0) begin
            calc_slot = 1'b1;
            s_nxt.dirty[s_r.ch] = 1'b1;
            s_nxt.left = s_r.left - 5'd1;
            s_nxt.ch = (s_r.scope == SC_PAIR) ? (s_r.ch ^ 4'h8) : (s_r.ch + 4'h1);
          end else begin
            s_nxt.st = ST_SELWAIT;
            s_nxt.cnt = 19'(SLOT_CYC - TAIL_CYC);
          end
        end
      end
      ST_SELWAIT: begin
        s_nxt.cnt = s_r.cnt + 19'd1;
        if (s_r.cnt == 19'(SLOT_CYC - 1)) begin
          s_nxt.st = ST_IDLE;
          s_nxt.busy_n = 1'b1;
          s_nxt.cnt = '0;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // writes are accepted in every state except the reset sequence
    if (s_r.dph && s_r.dwr && s_r.st != ST_RESET) begin
      if (s_r.daddr == OFS_SEL) begin
        s_nxt.sel = hwdata[NUM_CH-1:0];
        if (s_r.st == ST_IDLE) begin
          s_nxt.st = ST_SELWAIT;
          s_nxt.cnt = '0;
          s_nxt.busy_n = 1'b0;
        end
      end else if (s_r.daddr == OFS_WRITE) begin
        wr_go = 1'b1;
        s_nxt.cmd = hwdata;
        s_nxt.scope = hwdata[WR_SCOPE_LSB +: 2];
        s_nxt.st = ST_CALC;
        s_nxt.busy_n = 1'b0;
        s_nxt.cnt = '0;
        case (duc_scope_t'(hwdata[WR_SCOPE_LSB +: 2]))
          SC_ONE: begin
            s_nxt.ch = hwdata[WR_CH_LSB +: CH_W];
            s_nxt.left = 5'd1;
          end
          SC_PAIR: begin
            s_nxt.ch = {1'b0, hwdata[WR_CH_LSB +: 3]};
            s_nxt.left = 5'd2;
          end
          SC_GROUP: begin
            s_nxt.ch = {hwdata[WR_CH_LSB + 3], 3'b000};
            s_nxt.left = 5'd8;
          end
          default: begin
            s_nxt.ch = '0;
            s_nxt.left = 5'd16;
          end
        endcase
      end
    end
    // rising reset edge only; low level is ignored
    if (!s_r.rst_d && s_r.rst_s[1]) begin
      s_nxt.st = ST_RESET;
      s_nxt.cnt = '0;
      s_nxt.busy_n = 1'b0;
      s_nxt.dirty = '1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.rst_s <= 2'b11;
      s_r.rst_d <= 1'b1;
      s_r.clr_s <= 2'b11;
      s_r.ld_s <= 2'b11;
      s_r.ld_d <= 1'b1;
      s_r.busy_s <= 2'b11;
      s_r.busy_n <= 1'b1;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // per-channel storage; input registers update at write, computed codes per slot
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      localparam logic [CH_W-1:0] CH_IDX = CH_W'(g);
      logic hit;
      assign hit = wr_go && (hwdata[WR_SCOPE_LSB +: 2] == SC_ALL ||
        (hwdata[WR_SCOPE_LSB +: 2] == SC_GROUP && hwdata[WR_CH_LSB + 3] == CH_IDX[3]) ||
        (hwdata[WR_SCOPE_LSB +: 2] == SC_PAIR && hwdata[WR_CH_LSB +: 3] == CH_IDX[2:0]) ||
        (hwdata[WR_SCOPE_LSB +: 2] == SC_ONE && hwdata[WR_CH_LSB +: CH_W] == CH_IDX));
      always_ff @(posedge clk) begin
        if (rst || init_go) begin
          inp_a[g] <= INPUT_DEF;
          inp_b[g] <= INPUT_DEF;
          gain[g] <= GAIN_DEF;
          offs[g] <= OFFS_DEF;
          cc_a[g] <= INPUT_DEF;
          cc_b[g] <= INPUT_DEF;
          outr[g] <= INPUT_DEF;
        end else begin
          if (hit) begin
            case (duc_tgt_t'(hwdata[WR_TGT_LSB +: 3]))
              TGT_INPUT_A: inp_a[g] <= hwdata[CODE_W-1:0];
              TGT_INPUT_B: inp_b[g] <= hwdata[CODE_W-1:0];
              TGT_GAIN: gain[g] <= hwdata[CODE_W-1:0];
              TGT_OFFS: offs[g] <= hwdata[CODE_W-1:0];
              default: ;
            endcase
          end
          if (calc_slot && cur_ch == CH_IDX) begin
            if (cmd_tgt != TGT_INPUT_B) begin
              cc_a[g] <= res_a;
            end
            if (cmd_tgt != TGT_INPUT_A) begin
              cc_b[g] <= res_b;
            end
          end
          // clear never touches the output registers
          if (do_load && s_r.dirty[g]) begin
            outr[g] <= s_r.sel[g] ? cc_b[g] : cc_a[g];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    hrdata = s_r.rdata;
    hreadyout = 1'b1;
    hresp = 1'b0;
    busy_n_out = 1'b0;
    busy_n_oe_n = s_r.busy_n;
    group_signal_ground = s_r.gnd;
  end

  property p_no_load_in_clear;
    @(posedge clk) disable iff (rst) !s_r.clr_s[1] |=> !s_r.pend;
  endproperty
  a_no_load_in_clear: assert property (p_no_load_in_clear) else $error("load kept in clear");
  property p_one_ch_busy;
    @(posedge clk) disable iff (rst)
      (s_r.st == ST_IDLE && s_nxt.st == ST_CALC && s_nxt.left == 5'd1) |=> !s_r.busy_n [*8];
  endproperty
  a_one_ch_busy: assert property (p_one_ch_busy) else $error("busy too short");
  property p_clr_grounds; !s_r.clr_s[1] |=> group_signal_ground == '1; endproperty
  a_clr_grounds: assert property (p_clr_grounds) else $error("ground not switched");
  property p_no_load_busy; (!s_r.busy_n || !s_r.busy_s[1]) |=> $stable(s_r.loads); endproperty
  a_no_load_busy: assert property (p_no_load_busy) else $error("transfer while busy");
  property p_reset_seq;
    (!s_r.rst_d && s_r.rst_s[1]) |=> (s_r.st == ST_RESET && !busy_n_oe_n);
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset edge missed");
  property p_low_ignored;
    (s_r.st != ST_RESET && !s_r.rst_s[1]) |=> s_r.st != ST_RESET;
  endproperty
  a_low_ignored: assert property (p_low_ignored) else $error("low reset level acted on");
  property p_sel_busy;
    (s_r.dph && s_r.dwr && s_r.daddr == OFS_SEL && s_r.st == ST_IDLE) |=> !busy_n_oe_n [*8];
  endproperty
  a_sel_busy: assert property (p_sel_busy) else $error("select write not busy");
endmodule : duc_ctrl

//--- core/duc_pkg.sv
// package: register map, field layouts, defaults and timing counts for the dac update control
package duc_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned CODE_W = 16;
  localparam int unsigned CH_W = 4;
  // timing in ns
  localparam int unsigned RESET_SEQ_NS = 300000;
  localparam int unsigned CALC_SLOT_NS = 600;
  localparam int unsigned CALC_TAIL_NS = 300;
  localparam int unsigned RESET_SEQ_CYC = RESET_SEQ_NS * CLK_MHZ / 1000;
  localparam int unsigned SLOT_CYC = CALC_SLOT_NS * CLK_MHZ / 1000;
  localparam int unsigned TAIL_CYC = CALC_TAIL_NS * CLK_MHZ / 1000;
  // defaults
  localparam logic [15:0] INPUT_DEF = 16'h8000;
  localparam logic [15:0] GAIN_DEF = 16'hffff;
  localparam logic [15:0] OFFS_DEF = 16'h8000;
  localparam logic [15:0] HALF_SCALE = 16'h8000;
  // register byte offsets (ahb-lite word registers)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_SEL = 12'h008;
  localparam logic [11:0] OFS_WRITE = 12'h00c;
  localparam logic [11:0] OFS_OUT_BASE = 12'h100;
  // write command fields: data[15:0], ch[19:16], target[22:20], scope[25:24]
  localparam int unsigned WR_CH_LSB = 16;
  localparam int unsigned WR_TGT_LSB = 20;
  localparam int unsigned WR_SCOPE_LSB = 24;
  typedef enum logic [2:0] {
    TGT_INPUT_A = 3'b000,
    TGT_INPUT_B = 3'b001,
    TGT_GAIN = 3'b010,
    TGT_OFFS = 3'b011
  } duc_tgt_t;
  typedef enum logic [1:0] {
    SC_ONE = 2'b00,
    SC_PAIR = 2'b01,
    SC_GROUP = 2'b10,
    SC_ALL = 2'b11
  } duc_scope_t;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_IDLE = 2'b01,
    ST_CALC = 2'b10,
    ST_SELWAIT = 2'b11
  } duc_state_t;
endpackage : duc_pkg

//--- core/duc_calc.sv
// single shared multiplier: code = x*(m+1)/2^16 + c - 2^15
`timescale 1ns/1ns
module duc_calc (
  input wire logic [duc_pkg::CODE_W-1:0] x,
  input wire logic [duc_pkg::CODE_W-1:0] m,
  input wire logic [duc_pkg::CODE_W-1:0] c,
  output logic [duc_pkg::CODE_W-1:0] y
);
  import duc_pkg::*;
  logic [33:0] prod;
  logic [18:0] sum;
  always_comb begin
    prod = 34'(x) * (34'(m) + 34'h1);
    sum = 19'(prod[33:16]) + 19'(c) - 19'(HALF_SCALE);
    // clamp to code range; result outside 0..65535 would wrap
    if (sum[18]) begin
      y = '0;
    end else if (sum[17:16] != 2'b00) begin
      y = '1;
    end else begin
      y = sum[15:0];
    end
  end
endmodule : duc_calc

//--- verif/duc_host.sv
// host model: reset, clear and load lines plus a second device on busy
`timescale 1ns/1ns
module duc_host (
  input wire logic clk,
  output logic reset_n,
  output logic clear_to_ground_n,
  output logic load_outputs_n,
  output logic peer_busy_oe_n
);
  initial begin
    reset_n = 1'b1;
    clear_to_ground_n = 1'b1;
    load_outputs_n = 1'b1;
    peer_busy_oe_n = 1'b1;
  end
  // sel: 0 reset, 1 clear, 2 load, 3 peer busy enable (low pulls wire)
  task automatic drive(input int sel, input logic lvl);
    @(posedge clk);
    case (sel)
      0: reset_n <= lvl;
      1: clear_to_ground_n <= lvl;
      2: load_outputs_n <= lvl;
      default: peer_busy_oe_n <= lvl;
    endcase
  endtask : drive
  // three cycles low, well past the synchroniser
  task automatic strobe();
    drive(2, 1'b0);
    repeat (2) @(posedge clk);
    drive(2, 1'b1);
  endtask : strobe
endmodule : duc_host

//--- verif/tb.sv
// self-checking bench for the dac update control
`timescale 1ns/1ns
module tb;
  import duc_pkg::*;
  logic clk, rst, hwrite, hsel, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic reset_n, clr_n, load_n, peer_n, busy_out, busy_oe_n, busy_w;
  logic [15:0] gnd;
  logic [15:0] eo [16];
  int failures = 0, n_compared = 0, cycles = 0, n;
  int cnt [4] = '{1, 2, 8, 16};
  assign hready = hreadyout;
  // pull-up: wire high unless some device enables its driver
  assign busy_w = (busy_oe_n ? 1'b1 : busy_out) & peer_n;
  duc_ctrl #(.RESET_CYC(20)) u_dut (.clk(clk), .rst(rst), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reset_n(reset_n),
    .clear_to_ground_n(clr_n), .load_outputs_n(load_n), .busy_n_in(busy_w),
    .busy_n_out(busy_out), .busy_n_oe_n(busy_oe_n), .group_signal_ground(gnd));
  duc_host u_host (.clk(clk), .reset_n(reset_n), .clear_to_ground_n(clr_n),
    .load_outputs_n(load_n), .peer_busy_oe_n(peer_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic cmd(input logic [2:0] t, input logic [1:0] s, input logic [3:0] ch,
                     input logic [15:0] d);
    xfer(1'b1, {20'h0, OFS_WRITE}, {6'h0, s, 1'b0, t, ch, d});
  endtask : cmd
  task automatic busy_len(output int len);
    int w = 0;
    len = 0;
    while (busy_oe_n !== 1'b0 && w < 10) begin
      @(posedge clk);
      w++;
    end
    while (busy_oe_n === 1'b0 && len < 2000) begin
      @(posedge clk);
      len++;
    end
  endtask : busy_len
  task automatic wait_idle();
    int w = 0;
    // own busy shows only after the edge at which the write lands
    repeat (2) @(posedge clk);
    while ((busy_w !== 1'b1 || busy_oe_n !== 1'b1) && w < 3000) begin
      @(posedge clk);
      w++;
    end
    if (w >= 3000) begin
      failures++;
      $display("[FAIL] %0t busy never released", $time);
    end
    repeat (8) @(posedge clk);
  endtask : wait_idle
  task automatic check_all();
    for (int i = 0; i < 16; i++) begin
      xfer(1'b0, {20'h0, OFS_OUT_BASE} + 32'(4 * i), 32'h0);
      chk(rd, {16'h0, eo[i]});
    end
  endtask : check_all
  task automatic ld();
    u_host.strobe();
    wait_idle();
    check_all();
  endtask : ld
  function automatic logic [15:0] calc(input logic [15:0] x, m, c);
    longint v;
    v = ((longint'(x) * (longint'(m) + 1)) >> 16) + longint'(c) - 32768;
    return (v < 0) ? 16'h0 : (v > 65535) ? 16'hffff : 16'(v);
  endfunction : calc
  initial begin
    rst = 1'b1;
    hsel = 1'b1;
    hsize = 3'b010;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    for (int i = 0; i < 16; i++) eo[i] = 16'h8000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check_all();
    xfer(1'b0, 32'h0000_0080, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    // one, pair, group and all, each from channel 1
    for (int s = 0; s < 4; s++) begin
      cmd(TGT_INPUT_A, 2'(s), 4'h1, 16'h1000 * 16'(s + 1));
      busy_len(n);
      chk(n, (cnt[s] + 1) * SLOT_CYC + TAIL_CYC);
      for (int i = 0; i < 16; i++)
        if (s == 3 || (s == 2 && i < 8) || i == 1 || (s == 1 && i == 9))
          eo[i] = 16'h1000 * 16'(s + 1);
      ld();
    end
    cmd(TGT_GAIN, SC_ONE, 4'h0, 16'h7fff);
    cmd(TGT_OFFS, SC_ONE, 4'h0, 16'h8010);
    eo[0] = calc(eo[0], 16'h7fff, 16'h8010);
    ld();
    cmd(TGT_INPUT_A, SC_ONE, 4'h2, 16'h0abc);
    u_host.strobe();
    xfer(1'b0, {20'h0, OFS_OUT_BASE} + 32'h8, 32'h0);
    chk(rd, {16'h0, eo[2]});
    eo[2] = 16'h0abc;
    wait_idle();
    check_all();
    cmd(TGT_INPUT_B, SC_ONE, 4'h5, 16'h2222);
    ld();
    xfer(1'b1, {20'h0, OFS_SEL}, 32'h0000_0020);
    busy_len(n);
    chk(n, SLOT_CYC);
    ld();
    cmd(TGT_INPUT_B, SC_ONE, 4'h5, 16'h3333);
    eo[5] = 16'h3333;
    ld();
    u_host.drive(3, 1'b0);
    cmd(TGT_INPUT_A, SC_ONE, 4'h4, 16'h0444);
    u_host.strobe();
    repeat (90) @(posedge clk);
    check_all();
    u_host.drive(3, 1'b1);
    eo[4] = 16'h0444;
    wait_idle();
    check_all();
    u_host.drive(1, 1'b0);
    repeat (5) @(posedge clk);
    chk({16'h0, gnd}, 32'h0000ffff);
    cmd(TGT_INPUT_A, SC_ONE, 4'h6, 16'h0666);
    ld();
    u_host.drive(1, 1'b1);
    repeat (5) @(posedge clk);
    chk({16'h0, gnd}, 32'h0);
    check_all();
    eo[6] = 16'h0666;
    ld();
    u_host.drive(2, 1'b0);
    for (int k = 0; k < 2; k++) begin
      cmd(TGT_INPUT_A, SC_ONE, 4'h7, 16'h0770 + 16'(k));
      eo[7] = 16'h0770 + 16'(k);
      wait_idle();
      check_all();
    end
    u_host.drive(2, 1'b1);
    u_host.drive(0, 1'b0);
    repeat (20) @(posedge clk);
    xfer(1'b0, {20'h0, OFS_STATUS}, 32'h0);
    chk({31'h0, rd[3]}, 32'h0);
    chk({31'h0, busy_oe_n}, 32'h1);
    u_host.drive(0, 1'b1);
    repeat (5) @(posedge clk);
    xfer(1'b0, {20'h0, OFS_STATUS}, 32'h0);
    chk({31'h0, rd[3]}, 32'h1);
    // write inside the sequence must be dropped
    cmd(TGT_INPUT_A, SC_ONE, 4'h3, 16'h1111);
    wait_idle();
    for (int i = 0; i < 16; i++) eo[i] = 16'h8000;
    check_all();
    cmd(TGT_OFFS, SC_ONE, 4'h3, 16'h8000);
    cmd(TGT_INPUT_A, SC_ONE, 4'h0, 16'h2000);
    eo[0] = 16'h2000;
    ld();
    end_of_test();
  end
endmodule : tb
